/* File: pcca_consts.svh */
// constants for the pulse command capture arbiter
`ifndef PCCA_CONSTS_SVH
`define PCCA_CONSTS_SVH
`define CLK_MHZ        50
`define MS_US          1000
`define MS_CYCLES      (`MS_US * `CLK_MHZ)
`define PULSE_LOSS_MS  500
`define REF_MIN_US     1000
`define REF_CTR_US     1500
`define REF_MAX_US     2000
`define REF_MIN        (`REF_MIN_US * `CLK_MHZ)
`define REF_CTR        (`REF_CTR_US * `CLK_MHZ)
`define REF_MAX        (`REF_MAX_US * `CLK_MHZ)
`define CMD_FULL       1000
`define CNT_MAX        20'hF_FFFF
`define OFS_CTRL       8'h00
`define OFS_PRIO       8'h04
`define OFS_DBAND      8'h08
`define OFS_WDOG       8'h0C
`define OFS_DFLT       8'h10
`define OFS_RATES      8'h14
`define OFS_RMIN       8'h18
`define OFS_RCTR       8'h1C
`define OFS_RMAX       8'h20
`define OFS_CAL        8'h24
`define OFS_STATUS     8'h28
`define OFS_MEAS0      8'h2C
`define OFS_MEAS1      8'h30
`define OFS_MOTOR      8'h34
`define CTRL_RST       10'h100
`define PRIO_RST       6'h39
`define DBAND_RST      10'h000
`define WDOG_RST       16'h03E8
`define DFLT_RST       12'h000
`define RATES_RST      16'h0A0A
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define CTRL_DUTY_LSB  2
`define CTRL_CURVE_LSB 4
`define CTRL_MSEL_LSB  7
`endif

/* File: pcca_pkg.sv */
// types for the pulse command capture arbiter
package pcca_pkg;
  typedef enum logic [1:0] {PRI_NONE, PRI_SERIAL, PRI_PULSE, PRI_ANALOG} prio_e;
  typedef enum logic [2:0] {SRC_NONE, SRC_SCRIPT, SRC_CAN, SRC_SERIAL, SRC_PULSE,
                            SRC_ANALOG} src_e;
  typedef struct packed {
    logic [1:0][2:0]      psync;
    logic [2:0]           isync;
    logic [1:0]           plev;
    logic                 ilev;
    logic [1:0][19:0]     hi_cnt;
    logic [1:0][19:0]     per_cnt;
    logic [1:0][19:0]     hi_lat;
    logic [1:0][19:0]     meas;
    logic [1:0][15:0]     p_ms;
    logic [1:0]           p_seen;
    logic [2:0][15:0]     s_ms;
    logic [2:0]           s_seen;
    logic [2:0][1:0][11:0] s_cmd;
    logic [1:0][11:0]     ch_cmd;
    logic [1:0][11:0]     tgt;
    logic [1:0][11:0]     motor;
    logic                 pmode;
    logic [15:0]          tick_cnt;
    logic                 tick;
    src_e                 src;
    logic [9:0]           ctrl;
    logic [5:0]           prio;
    logic [9:0]           dband;
    logic [15:0]          wdog;
    logic [11:0]          dflt;
    logic [15:0]          rates;
    logic [19:0]          rmin;
    logic [19:0]          rctr;
    logic [19:0]          rmax;
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic                 bvalid;
    logic                 rvalid;
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [1:0]           bresp;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
  } st_s;
endpackage : pcca_pkg

/* File: pulse_command_capture_arbiter.sv */
// pulse width capture, command scaling and command source arbitration
// Overview of operation
// RL1 - script ranks first, CAN second; serial, pulse, analog follow configured order
// RL2 - script and CAN commands expire on the same watchdog as serial
// RL3 - default references: 1.0 ms minimum, 1.5 ms centre, 2.0 ms maximum
// RL4 - width measured in 20 ns steps, far finer than 0.1 percent
// RL5 - width against references gives -1000 at min, 0 centre, +1000 max
// RL6 - references writable and capturable from the live input for calibration
// RL7 - commands within the deadband around centre become zero
// RL8 - optional choice of five exponential or logarithmic correction curves
// RL9 - valid pulses on any enabled input make pulse mode active
// RL10 - pulse commands drive motors only when no higher source is active
// RL11 - no valid pulse for over 500 ms drops pulse mode
// RL12 - capture runs straight out of reset with no enabling step; the input enable bits in ctrl reset to zero
// RL13 - sensor pulse repetition must stay at or below 250 Hz
// RL14 - sensor pulses should stay at least 10 us wide
// RL15 - an input with no edges at all counts as lost
// RL16 - pulse mode measures high time only
// RL17 - duty mode measures high time relative to the full period
// RL18 - sensor and radio widths share scaling, deadband, curves and watchdog
// RL19 - any input selectable per motor; default input 0 and input 1
// RL20 - active invert input negates the motor command
// RL21 - on inversion, ramp to zero by deceleration then up by acceleration
// RL22 - with no active source, apply the settable default command
// RL23 - serial active only while commands arrive within the watchdog time
// RL24 - linear between references, saturating at plus or minus 1000
// RL25 - highest-priority active source alone feeds the motor path
`timescale 1ns/1ps
`include "pcca_consts.svh"

module pulse_command_capture_arbiter #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // axi4-lite slave
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // pins
  input  wire logic [1:0]             pulse_in,
  input  wire logic                   invert_in,
  // other command sources, one 12-bit signed command per motor
  input  wire logic [1:0][11:0]       script_cmd,
  input  wire logic                   script_stb,
  input  wire logic [1:0][11:0]       can_cmd,
  input  wire logic                   can_stb,
  input  wire logic [1:0][11:0]       serial_cmd,
  input  wire logic                   serial_stb,
  input  wire logic [1:0][11:0]       analog_cmd,
  input  wire logic                   analog_active,
  // motor path
  output logic [1:0][11:0]            motor_cmd,
  output logic                        pulse_mode_active,
  output logic [2:0]                  cmd_source
);

  pcca_pkg::st_s s;
  pcca_pkg::st_s n;
  logic [2:0]    act;
  logic [1:0]    palive;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) r[8*k +: 8] = d[8*k +: 8];
    end
    return r;
  endfunction : wmerge

  function automatic logic [11:0] scale(input logic [19:0] w, input logic [19:0] lo,
                                        input logic [19:0] c, input logic [19:0] hi);
    int r;
    r = 0;
    if (w >= hi) r = `CMD_FULL;
    else if (w <= lo) r = -`CMD_FULL;
    else if (w >= c) r = (int'(w - c) * `CMD_FULL) / int'(hi - c);
    else r = -((int'(c - w) * `CMD_FULL) / int'(c - lo));
    return 12'(r);
  endfunction : scale

  // curve 0 linear, 1..3 stronger exponential, 4..5 logarithmic
  function automatic logic [11:0] shape(input logic [11:0] x, input logic [9:0] db,
                                        input logic [2:0] crv);
    int v;
    int a;
    int sq;
    v = int'($signed(x));
    a = (v < 0) ? -v : v;
    sq = (v * a) / `CMD_FULL;
    if (a <= int'(db)) v = 0;
    else if (crv >= 3'h1 && crv <= 3'h3) v = (v * (4 - int'(crv)) + sq * int'(crv)) / 4;
    else if (crv == 3'h4) v = (v * 2 + (2 * v - sq) * 2) / 4;
    else if (crv == 3'h5) v = 2 * v - sq;
    return 12'(v);
  endfunction : shape

  function automatic logic [11:0] ramp(input logic [11:0] cur, input logic [11:0] tgt,
                                       input logic [7:0] acc, input logic [7:0] dec);
    int c;
    int t;
    int g;
    int st;
    c = int'($signed(cur));
    t = int'($signed(tgt));
    // crossing zero always goes through zero on the deceleration rate
    if ((c > 0 && t < c) || (c < 0 && t > c)) begin
      g = ((c > 0) == (t > 0)) ? t : 0;
      st = int'(dec);
    end else begin
      g = t;
      st = int'(acc);
    end
    if (g > c) c = (c + st > g) ? g : c + st;
    else c = (c - st < g) ? g : c - st;
    return 12'(c);
  endfunction : ramp

  // a source stays active only while the watchdog has not run out; zero disables it
  for (genvar k = 0; k < 3; k++) begin : g_act
    assign act[k] = s.s_seen[k] && (s.wdog == 16'h0000 || s.s_ms[k] < s.wdog); // RL2 RL23
  end
  for (genvar k = 0; k < 2; k++) begin : g_alive
    assign palive[k] = s.ctrl[k] && s.p_seen[k] &&
                       (s.p_ms[k] <= 16'(`PULSE_LOSS_MS)); // RL11 RL15
  end

  always_comb begin
    logic        nl;
    logic        rise;
    logic        fall;
    logic        duty;
    logic        ok;
    logic        csel;
    logic [1:0]  pr;
    logic [11:0] raw;
    logic [2:0]  stb;
    logic [31:0] rd;
    logic [19:0] cw;
    pcca_pkg::src_e sel;
    nl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    duty = 1'b0;
    ok = 1'b0;
    csel = 1'b0;
    pr = 2'h0;
    raw = 12'h000;
    stb = {serial_stb, can_stb, script_stb};
    rd = 32'h0000_0000;
    cw = 20'h0_0000;
    sel = pcca_pkg::SRC_NONE;
    n = s;
    n.tick = (s.tick_cnt == 16'(MS_CYCLES - 1));
    n.tick_cnt = n.tick ? 16'h0000 : s.tick_cnt + 16'h0001;

    // pin inputs: three stages, level taken once stages two and three agree
    n.isync = {s.isync[1:0], invert_in};
    if (s.isync[1] == s.isync[2]) n.ilev = s.isync[2];
    for (int i = 0; i < 2; i++) begin
      n.psync[i] = {s.psync[i][1:0], pulse_in[i]};
      nl = (s.psync[i][1] == s.psync[i][2]) ? s.psync[i][2] : s.plev[i];
      n.plev[i] = nl;
      rise = nl && !s.plev[i];
      fall = !nl && s.plev[i];
      duty = s.ctrl[`CTRL_DUTY_LSB + i];
      ok = 1'b0;
      if (rise) begin
        n.per_cnt[i] = 20'h0_0001;
        n.hi_cnt[i] = 20'h0_0001;
        if (duty && s.hi_lat[i] != 20'h0_0000 && s.per_cnt[i] != `CNT_MAX) begin
          n.meas[i] = 20'(({s.hi_lat[i], 16'h0000}) / {16'h0000, s.per_cnt[i]}); // RL17
          ok = 1'b1;
        end
      end else begin
        if (s.per_cnt[i] != `CNT_MAX) n.per_cnt[i] = s.per_cnt[i] + 20'h0_0001;
        if (nl && s.hi_cnt[i] != `CNT_MAX) n.hi_cnt[i] = s.hi_cnt[i] + 20'h0_0001; // RL4
      end
      if (fall) begin
        n.hi_lat[i] = s.hi_cnt[i];
        if (!duty && s.hi_cnt[i] != `CNT_MAX) begin
          n.meas[i] = s.hi_cnt[i]; // RL16
          ok = 1'b1;
        end
      end
      if (ok) begin
        n.p_ms[i] = 16'h0000;
        n.p_seen[i] = 1'b1; // RL9
      end else if (s.tick && s.p_ms[i] != 16'hFFFF) begin
        n.p_ms[i] = s.p_ms[i] + 16'h0001;
      end
      n.ch_cmd[i] = scale(s.meas[i], s.rmin, s.rctr, s.rmax); // RL5 RL24 RL18
    end
    n.pmode = |palive;

    for (int k = 0; k < 3; k++) begin
      if (stb[k]) begin
        n.s_seen[k] = 1'b1;
        n.s_ms[k] = 16'h0000;
      end else if (s.tick && s.s_ms[k] != 16'hFFFF) begin
        n.s_ms[k] = s.s_ms[k] + 16'h0001;
      end
    end
    if (script_stb) n.s_cmd[0] = script_cmd;
    if (can_stb) n.s_cmd[1] = can_cmd;
    if (serial_stb) n.s_cmd[2] = serial_cmd;

    // fixed ranks first, then the three configured levels
    if (act[0]) sel = pcca_pkg::SRC_SCRIPT; // RL1
    else if (act[1]) sel = pcca_pkg::SRC_CAN; // RL1
    else begin
      for (int l = 2; l >= 0; l--) begin
        pr = s.prio[2*l +: 2];
        if (pr == pcca_pkg::PRI_SERIAL && act[2]) sel = pcca_pkg::SRC_SERIAL;
        else if (pr == pcca_pkg::PRI_PULSE && s.pmode) sel = pcca_pkg::SRC_PULSE; // RL10
        else if (pr == pcca_pkg::PRI_ANALOG && analog_active) sel = pcca_pkg::SRC_ANALOG;
      end
    end
    n.src = sel; // RL25

    for (int m = 0; m < 2; m++) begin
      csel = s.ctrl[`CTRL_MSEL_LSB + m];
      case (s.src)
        pcca_pkg::SRC_SCRIPT: raw = s.s_cmd[0][m];
        pcca_pkg::SRC_CAN:    raw = s.s_cmd[1][m];
        pcca_pkg::SRC_SERIAL: raw = s.s_cmd[2][m];
        pcca_pkg::SRC_PULSE:  raw = s.ch_cmd[csel]; // RL19
        pcca_pkg::SRC_ANALOG: raw = analog_cmd[m];
        default:              raw = s.dflt; // RL22
      endcase
      if (s.src != pcca_pkg::SRC_NONE) begin
        raw = shape(raw, s.dband, s.ctrl[`CTRL_CURVE_LSB +: 3]); // RL7 RL8
      end
      n.tgt[m] = s.ilev ? 12'(-$signed(raw)) : raw; // RL20
      if (s.tick) n.motor[m] = ramp(s.motor[m], s.tgt[m], s.rates[7:0], s.rates[15:8]); // RL21
    end

    // register bus: address and data in either order, answer after both
    if (awvalid && s.awready) begin
      n.awaddr = awaddr;
      n.aw_got = 1'b1;
      n.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      n.wdata = wdata;
      n.wstrb = wstrb;
      n.w_got = 1'b1;
      n.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      if (s.awaddr == `OFS_CTRL) n.ctrl = 10'(wmerge(32'(s.ctrl), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_PRIO) n.prio = 6'(wmerge(32'(s.prio), s.wdata, s.wstrb)); // RL1
      else if (s.awaddr == `OFS_DBAND) n.dband = 10'(wmerge(32'(s.dband), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_WDOG) n.wdog = 16'(wmerge(32'(s.wdog), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_DFLT) n.dflt = 12'(wmerge(32'(s.dflt), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_RATES) n.rates = 16'(wmerge(32'(s.rates), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_RMIN) n.rmin = 20'(wmerge(32'(s.rmin), s.wdata, s.wstrb)); // RL6
      else if (s.awaddr == `OFS_RCTR) n.rctr = 20'(wmerge(32'(s.rctr), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_RMAX) n.rmax = 20'(wmerge(32'(s.rmax), s.wdata, s.wstrb));
      else if (s.awaddr == `OFS_CAL) begin
        // calibration grabs the live measurement of the chosen input
        cw = s.meas[s.wdata[4]];
        if (s.wdata[0]) n.rmin = cw; // RL6
        if (s.wdata[1]) n.rctr = cw;
        if (s.wdata[2]) n.rmax = cw;
      end else if (s.awaddr == `OFS_STATUS || s.awaddr == `OFS_MEAS0 ||
                   s.awaddr == `OFS_MEAS1 || s.awaddr == `OFS_MOTOR) n.bresp = `RESP_OKAY;
      else n.bresp = `RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      if (araddr == `OFS_CTRL) rd = 32'(s.ctrl);
      else if (araddr == `OFS_PRIO) rd = 32'(s.prio);
      else if (araddr == `OFS_DBAND) rd = 32'(s.dband);
      else if (araddr == `OFS_WDOG) rd = 32'(s.wdog);
      else if (araddr == `OFS_DFLT) rd = 32'(s.dflt);
      else if (araddr == `OFS_RATES) rd = 32'(s.rates);
      else if (araddr == `OFS_RMIN) rd = 32'(s.rmin);
      else if (araddr == `OFS_RCTR) rd = 32'(s.rctr);
      else if (araddr == `OFS_RMAX) rd = 32'(s.rmax);
      else if (araddr == `OFS_CAL) rd = 32'h0000_0000;
      else if (araddr == `OFS_STATUS) rd = {19'h0_0000, s.ilev, 1'b0, act, 2'h0, palive,
                                            1'b0, s.src};
      else if (araddr == `OFS_MEAS0) rd = 32'(s.meas[0]);
      else if (araddr == `OFS_MEAS1) rd = 32'(s.meas[1]);
      else if (araddr == `OFS_MOTOR) rd = {4'h0, s.motor[1], 4'h0, s.motor[0]};
      else n.rresp = `RESP_SLVERR;
      n.rdata = rd;
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // capture is live from reset with no arming step, but the input enable bits in ctrl reset to zero
    if (!nrst) begin
      n = '0;
      n.ctrl = `CTRL_RST; // RL12 RL19
      n.prio = `PRIO_RST;
      n.dband = `DBAND_RST;
      n.wdog = `WDOG_RST;
      n.dflt = `DFLT_RST;
      n.rates = `RATES_RST;
      n.rmin = 20'(`REF_MIN); // RL3
      n.rctr = 20'(`REF_CTR);
      n.rmax = 20'(`REF_MAX);
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    s <= n;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign motor_cmd = s.motor;
  assign pulse_mode_active = s.pmode;
  assign cmd_source = s.src;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  script_first_a: assert property (act[0] |=> s.src == pcca_pkg::SRC_SCRIPT) // RL1
    else $error("script not selected while active");
  can_second_a: assert property (!act[0] && act[1] |=> s.src == pcca_pkg::SRC_CAN) // RL25
    else $error("can not selected over lower sources");
  script_wdog_a: assert property (s.wdog != 16'h0000 && s.s_ms[0] >= s.wdog // RL2
                                  |=> s.src != pcca_pkg::SRC_SCRIPT)
    else $error("script active past watchdog");
  serial_wdog_a: assert property (serial_stb |=> act[2] && s.s_ms[2] == 16'h0000) // RL23
    else $error("serial not active after command");
  pulse_loss_a: assert property (s.p_ms[0] > 16'(`PULSE_LOSS_MS) && // RL11
                                 s.p_ms[1] > 16'(`PULSE_LOSS_MS) |=> !pulse_mode_active)
    else $error("pulse mode kept after loss time");
  pulse_mode_a: assert property (palive != 2'b00 |=> pulse_mode_active) // RL9
    else $error("pulse mode not raised");
  cmd_range_a: assert property ($signed(s.ch_cmd[0]) <= 12'sd1000 && // RL5
                                $signed(s.ch_cmd[0]) >= -12'sd1000)
    else $error("scaled command out of range");
  centre_zero_a: assert property (s.meas[1] == s.rctr && $stable(s.meas[1]) && // RL24
                                  $stable(s.rctr) |=> s.ch_cmd[1] == 12'h000)
    else $error("centre width not zero");
  ramp_cross_a: assert property ($signed(s.motor[0]) > 0 |=> $signed(s.motor[0]) >= 0) // RL21
    else $error("motor jumped across zero");
  default_cmd_a: assert property (s.src == pcca_pkg::SRC_NONE && !s.ilev // RL22
                                  |=> s.tgt[0] == $past(s.dflt))
    else $error("default command not applied");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");

endmodule : pulse_command_capture_arbiter

/* File: rc_source_model.sv */
// behavioural pulse source standing in for a receiver or pwm angle sensor
`timescale 1ns/1ps

module rc_source_model #(
  parameter int MS_CYCLES = 50
) (
  // clock
  input  wire logic        mclk,
  // control from the bench
  input  wire logic        run,
  input  wire logic [19:0] width,
  input  wire logic [19:0] period,
  // pulse line
  output logic             line
);
  // repetition never faster than 250 hz, scaled to the ms tick
  localparam int MIN_PERIOD = 4 * MS_CYCLES;

  logic [19:0] cnt;
  logic [19:0] w_cur;
  logic [19:0] p_cur;
  logic        on;

  initial begin
    cnt = '0;
    w_cur = 20'h0_0001;
    p_cur = 20'(MIN_PERIOD);
    on = 1'b0;
    line = 1'b0;
  end

  // width and period only change at a period boundary, so no runt pulses
  always @(posedge mclk) begin
    if (cnt + 20'h0_0001 >= p_cur) begin
      cnt <= '0;
      on <= run;
      w_cur <= (width == 20'h0_0000) ? 20'h0_0001 : width;
      p_cur <= (period < 20'(MIN_PERIOD)) ? 20'(MIN_PERIOD) : period;
    end else begin
      cnt <= cnt + 20'h0_0001;
    end
    // stopped source sits at zero duty, the capture's reset level: no false edge
    line <= on ? (cnt < w_cur) : 1'b0;
  end
endmodule : rc_source_model

/* File: tb.sv */
// self-checking bench for the pulse command capture arbiter
`timescale 1ns/1ps
`include "pcca_consts.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module tb;
  logic             mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready, invert_in, pulse_mode_active;
  logic             script_stb, can_stb, serial_stb, analog_active;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, rd;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp, rs, bs, pulse_in, run;
  logic [2:0]       cmd_source;
  logic [1:0][11:0] script_cmd, can_cmd, serial_cmd, analog_cmd, motor_cmd;
  logic [1:0][19:0] wid;
  int               n_mismatch, tests_run;
  int               wt[6] = '{100, 125, 150, 175, 250, 50};
  int               ct[6] = '{-1000, -500, 0, 500, 1000, -1000};

  pulse_command_capture_arbiter #(.MS_CYCLES(50)) u_pulse_command_capture_arbiter (
    .mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .pulse_in, .invert_in, .script_cmd, .script_stb, .can_cmd, .can_stb, .serial_cmd,
    .serial_stb, .analog_cmd, .analog_active, .motor_cmd, .pulse_mode_active, .cmd_source);
  // 400-cycle period stands for 8 ms at the shortened tick
  rc_source_model #(.MS_CYCLES(50)) u_src0 (.mclk, .run(run[0]), .width(wid[0]),
    .period(20'h0_0190), .line(pulse_in[0]));
  rc_source_model #(.MS_CYCLES(50)) u_src1 (.mclk, .run(run[1]), .width(wid[1]),
    .period(20'h0_0190), .line(pulse_in[1]));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge mclk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    `CHK("reg", e, rd)
  endtask : rd_chk

  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF;
    invert_in = 1'b0; script_stb = 1'b0; can_stb = 1'b0; serial_stb = 1'b0;
    analog_active = 1'b0; run = 2'b00; script_cmd = '0; can_cmd = '0; serial_cmd = '0;
    analog_cmd = '0; wid = {2{20'h0_0096}}; n_mismatch = 0; tests_run = 0;
    cyc(8);
    nrst <= 1'b1;
    cyc(2);
    `CHK("motor", 24'h00_0000, motor_cmd)
    `CHK("source", 3'h0, cmd_source)
    rd_chk(`OFS_CTRL, 32'h0000_0100);
    rd_chk(`OFS_PRIO, 32'h0000_0039);
    rd_chk(`OFS_WDOG, 32'h0000_03E8);
    rd_chk(`OFS_RMIN, 32'(`REF_MIN));
    rd_chk(`OFS_RCTR, 32'(`REF_CTR));
    rd_chk(`OFS_RMAX, 32'(`REF_MAX));
    rd_chk(8'h3C, 32'h0000_0000);
    `CHK("rresp", 2'h2, rs)
    wr(8'h3C, 32'h0000_0000);
    `CHK("bresp", 2'h2, bs)
    // short references keep every pulse well inside the run budget
    wr(`OFS_RMIN, 32'h0000_0064);
    wr(`OFS_RCTR, 32'h0000_0096);
    wr(`OFS_RMAX, 32'h0000_00C8);
    wr(`OFS_RATES, 32'h0000_FFFF);
    wr(`OFS_WDOG, 32'h0000_0014);
    wr(`OFS_CTRL, 32'h0000_0103);
    `CHK("bresp", 2'h0, bs)
    run <= 2'b11;
    for (int i = 0; i < 6; i++) begin
      wid[0] <= 20'(wt[i]);
      cyc(1300);
      `CHK("motor0", 12'(ct[i]), motor_cmd[0])
    end
    wid[0] <= 20'h0_00AF;
    cyc(1300);
    rd_chk(`OFS_MEAS0, 32'h0000_00AF);
    `CHK("active", 1'b1, pulse_mode_active)
    `CHK("source", 3'(pcca_pkg::SRC_PULSE), cmd_source)
    `CHK("motor1", 12'h000, motor_cmd[1])
    wr(`OFS_CAL, 32'h0000_0002);
    rd_chk(`OFS_RCTR, 32'h0000_00AF);
    wr(`OFS_RCTR, 32'h0000_0096);
    wr(`OFS_CTRL, 32'h0000_0003);
    cyc(600);
    `CHK("motor1", 12'h1F4, motor_cmd[1])
    wr(`OFS_DBAND, 32'h0000_0064);
    wid[0] <= 20'h0_009A;
    cyc(1300);
    `CHK("motor0", 12'h000, motor_cmd[0])
    wr(`OFS_DBAND, 32'h0000_0000);
    for (int c = 1; c < 6; c++) begin
      wr(`OFS_CTRL, 32'h0000_0003 | (32'(c) << `CTRL_CURVE_LSB));
      wid[0] <= 20'h0_00C8;
      cyc(1300);
      `CHK("curve", 12'h3E8, motor_cmd[0])
      // exponential curves soften the midpoint, logarithmic ones sharpen it
      wid[0] <= 20'h0_00AF;
      cyc(1300);
      `CHK("curve mid", 1'(c < 4), 1'($signed(motor_cmd[0]) < 12'sd500))
    end
    wid[0] <= 20'h0_00C8;
    wr(`OFS_CTRL, 32'h0000_0003);
    serial_cmd <= {12'h000, 12'h12C};
    serial_stb <= 1'b1;
    cyc(1);
    serial_stb <= 1'b0;
    cyc(30);
    `CHK("source", 3'(pcca_pkg::SRC_SERIAL), cmd_source)
    can_cmd <= {12'h000, 12'h064};
    can_stb <= 1'b1;
    cyc(1);
    can_stb <= 1'b0;
    cyc(30);
    `CHK("source", 3'(pcca_pkg::SRC_CAN), cmd_source)
    script_cmd <= {12'h000, 12'hF38};
    script_stb <= 1'b1;
    cyc(1);
    script_stb <= 1'b0;
    cyc(600);
    `CHK("source", 3'(pcca_pkg::SRC_SCRIPT), cmd_source)
    `CHK("motor0", 12'hF38, motor_cmd[0])
    cyc(1200);
    `CHK("source", 3'(pcca_pkg::SRC_PULSE), cmd_source)
    wr(`OFS_PRIO, 32'h0000_001B);
    analog_cmd <= {12'h000, 12'h0C8};
    analog_active <= 1'b1;
    cyc(600);
    `CHK("source", 3'(pcca_pkg::SRC_ANALOG), cmd_source)
    `CHK("motor0", 12'h0C8, motor_cmd[0])
    analog_active <= 1'b0;
    cyc(30);
    `CHK("source", 3'(pcca_pkg::SRC_PULSE), cmd_source)
    invert_in <= 1'b1;
    cyc(1300);
    `CHK("motor0", 12'hC18, motor_cmd[0])
    invert_in <= 1'b0;
    // duty references are fractions of 65536: half duty lands on the maximum
    wr(`OFS_RMIN, 32'h0000_0000);
    wr(`OFS_RCTR, 32'h0000_4000);
    wr(`OFS_RMAX, 32'h0000_8000);
    wr(`OFS_CTRL, 32'h0000_0007);
    cyc(1300);
    `CHK("motor0", 12'h3E8, motor_cmd[0])
    wr(`OFS_DFLT, 32'h0000_0064);
    run <= 2'b00;
    cyc(24000);
    `CHK("active", 1'b1, pulse_mode_active)
    cyc(3000);
    `CHK("active", 1'b0, pulse_mode_active)
    `CHK("source", 3'h0, cmd_source)
    `CHK("motor0", 12'h064, motor_cmd[0])
    summarize();
  end

  // the tests need about 60000 cycles; this leaves ample margin
  initial begin
    cyc(90000);
    n_mismatch++;
    summarize();
  end
endmodule : tb
